// ---- verilog/sacc_regs.vh ----
`ifndef SACC_REGS_VH
`define SACC_REGS_VH
`define SACC_CLK_MHZ        250
`define SACC_CONV_NS        6000
`define SACC_CONV_CYC       ((`SACC_CONV_NS * `SACC_CLK_MHZ) / 1000)
`define SACC_SLEEP_WAKE_US  3000
`define SACC_SLEEP_WAKE_CYC (`SACC_SLEEP_WAKE_US * `SACC_CLK_MHZ)
`define SACC_NAP_WAKE_NS    620
`define SACC_NAP_WAKE_CYC   ((`SACC_NAP_WAKE_NS * `SACC_CLK_MHZ) / 1000)
`define SACC_MSB_FLIP       12'h800
`define SACC_ST_IDLE        2'd0
`define SACC_ST_CONV        2'd1
`define SACC_ST_WAKE        2'd2
`endif

// ---- verilog/sacc_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser; the first stage is read only by the second.
module sacc_sync #(
	parameter         W       = 1,
	parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
	input  wire         clock,
	input  wire         rstn,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_reg;

	// Reset loads each bit with the idle level of its pin, so no false edge follows reset.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= RST_VAL;
			q        <= RST_VAL;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/sacc_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "sacc_regs.vh"
module sacc_top #(
	parameter        CONV_CYC  = `SACC_CONV_CYC,
	parameter        SLEEP_CYC = `SACC_SLEEP_WAKE_CYC,
	parameter        NAP_CYC   = `SACC_NAP_WAKE_CYC,
	parameter [0:0]  BYTE_WIDE = 1'b0,
	parameter [0:0]  OFFSET_BIN = 1'b0
) (
	input  wire        clock,
	input  wire        rstn,
	input  wire        chip_select_n,
	input  wire        read_n,
	input  wire        conversion_start_n,
	input  wire        upper_byte_select,
	input  wire        sleep_n,
	input  wire        nap_n,
	input  wire        bipolar,
	input  wire        sample_valid,
	input  wire [11:0] sample_code,
	output reg         busy_n,
	output reg         reference_settled,
	output reg         comparator_on,
	output reg         analog_on,
	output reg  [11:0] data_out,
	output wire [11:0] data_oe,
	output reg         conv_done
);
	// Host strobes and mode levels are pins from another clock domain; each one
	// passes two flip-flops before any logic below reads it.
	localparam integer PIN_W = 7;
	wire [PIN_W-1:0] pins_s;
	sacc_sync #(
		.W       (PIN_W),
		.RST_VAL (7'h7c)
	) u_sync (
		.clock (clock),
		.rstn  (rstn),
		.d     ({chip_select_n, read_n, conversion_start_n, sleep_n, nap_n, upper_byte_select, bipolar}),
		.q     (pins_s)
	);

	// Named taps on the synchronised bus.  Strobes leave reset at their idle high level.
	wire cs_n_s  = pins_s[6];
	wire rd_n_s  = pins_s[5];
	wire cv_n_s  = pins_s[4];
	wire slp_n_s = pins_s[3];
	wire nap_n_s = pins_s[2];
	wire ubs_s   = pins_s[1];
	wire bip_s   = pins_s[0];

	// Sequencer state and the conversion timer.
	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [31:0] count_reg;
	reg  [31:0] count_next;
	reg         busy_next;
	reg         done_next;

	// Start edge memory; it resets high so that no false edge follows reset.
	reg         cv_prev_reg;

	// Result path: the latest core sample and the held conversion result.
	reg  [11:0] sample_reg;
	reg  [11:0] result_reg;
	reg  [11:0] result_next;

	// Power control: one counter per wake-up interval and their ready flags.
	reg  [31:0] wake_reg;
	reg  [31:0] wake_next;
	reg         settled_next;
	reg  [31:0] nap_reg;
	reg  [31:0] nap_next;
	reg         nap_ready_reg;
	reg         nap_ready_next;
	reg         power_next;

	// Next value of the registered data lines.
	reg  [11:0] data_next;

	// A falling edge on the synchronised start line, one cycle wide.
	wire cv_fall = cv_prev_reg & ~cv_n_s;

	// Conversions are allowed only when awake, settled and out of nap.  The settled
	// flag also covers the wake-up interval, so a start right after sleep is dropped.
	wire ready = slp_n_s & reference_settled & nap_ready_reg;

	// Chip select gates the edge, and a running conversion never looks at it.
	wire idle  = (state_reg == `SACC_ST_IDLE);
	wire start = idle & cv_fall & ~cs_n_s & ready;

	// Last cycle of the internal conversion time, counted from zero.  The timer
	// needs nothing from the bus strobes once the conversion has started.
	wire conv_last = (count_reg >= CONV_CYC - 1);

	// Output format: unipolar stays straight binary; two's complement flips the
	// sign bit of the offset code, offset binary passes it unchanged.
	wire [11:0] fmt_code = (bip_s & ~OFFSET_BIN) ? (sample_reg ^ `SACC_MSB_FLIP)
	                     : sample_reg;

	// Sequencer next state.  Start edges are looked at only in idle, which is what
	// keeps a running conversion from being restarted.
	always @* begin
		state_next = state_reg;
		count_next = count_reg;
		busy_next  = busy_n;
		done_next  = 1'b0;
		case (state_reg)
		`SACC_ST_IDLE: begin
			busy_next = 1'b1;
			if (start) begin
				state_next = `SACC_ST_CONV;
				count_next = 32'h0000_0000;
				busy_next  = 1'b0;
			end
		end
		`SACC_ST_CONV: begin
			if (conv_last) begin
				state_next = `SACC_ST_IDLE;
				busy_next  = 1'b1;
				done_next  = 1'b1;
			end else begin
				count_next = count_reg + 32'h0000_0001;
			end
		end
		default: begin
			state_next = `SACC_ST_IDLE;
			count_next = 32'h0000_0000;
			busy_next  = 1'b1;
		end
		endcase
	end

	// State register.  Reset leaves the block idle with nothing pending.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= `SACC_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Conversion timer.  It is cleared on every accepted start, so a stale count
	// from an earlier conversion can never shorten the next one.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count_reg <= 32'h0000_0000;
		end else begin
			count_reg <= count_next;
		end
	end

	// Busy status and the completion pulse share the same edge.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy_n    <= 1'b1;
			conv_done <= 1'b0;
		end else begin
			busy_n    <= busy_next;
			conv_done <= done_next;
		end
	end

	// Edge memory for the start line.  It follows the line in every state, so an
	// edge that falls during a conversion is used up and not replayed afterwards.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cv_prev_reg <= 1'b1;
		end else begin
			cv_prev_reg <= cv_n_s;
		end
	end

	// The core sample arrives on this clock and needs no synchroniser.  It is
	// taken whenever it is valid; only the completion edge freezes it into the result.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sample_reg <= 12'h000;
		end else if (sample_valid) begin
			sample_reg <= sample_code;
		end
	end

	// Result holding: the previous result stays until the conversion completes,
	// which is what slow-memory and ROM reads rely on.
	always @* begin
		result_next = result_reg;
		if (state_reg == `SACC_ST_CONV && conv_last)
			result_next = fmt_code;
	end

	// Result register.  It changes on the same edge on which busy goes high, so a
	// host that latches on the rising busy edge needs the one-cycle lag of the lines.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			result_reg <= 12'h000;
		end else begin
			result_reg <= result_next;
		end
	end

	// Reference wake-up after sleep.  The counter restarts every time sleep is
	// asserted, so a short sleep still costs the full settling interval.
	always @* begin
		wake_next    = wake_reg;
		settled_next = reference_settled;
		if (!slp_n_s) begin
			settled_next = 1'b0;
			wake_next    = 32'h0000_0000;
		end else if (!reference_settled) begin
			if (wake_reg >= SLEEP_CYC - 1)
				settled_next = 1'b1;
			else
				wake_next = wake_reg + 32'h0000_0001;
		end
	end

	// Nap recovery.  Only the short nap interval is waited for, since the
	// reference stays up through nap.
	always @* begin
		nap_next       = nap_reg;
		nap_ready_next = nap_ready_reg;
		if (!nap_n_s) begin
			nap_ready_next = 1'b0;
			nap_next       = 32'h0000_0000;
		end else if (!nap_ready_reg) begin
			if (nap_reg >= NAP_CYC - 1)
				nap_ready_next = 1'b1;
			else
				nap_next = nap_reg + 32'h0000_0001;
		end
	end

	// Sleep registers.  Reset comes up awake with the reference already settled,
	// which spares the long wake-up interval after every reset.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wake_reg          <= 32'h0000_0000;
			reference_settled <= 1'b1;
		end else begin
			wake_reg          <= wake_next;
			reference_settled <= settled_next;
		end
	end

	// Nap registers.  Reset comes up out of nap and ready to convert.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			nap_reg       <= 32'h0000_0000;
			nap_ready_reg <= 1'b1;
		end else begin
			nap_reg       <= nap_next;
			nap_ready_reg <= nap_ready_next;
		end
	end

	// The comparator and the rest of the analogue section are up only while both
	// sleep and nap are released.  The settled flag is not looked at, so after sleep
	// the comparator comes up before the reference has settled.
	always @* begin
		power_next = slp_n_s & nap_n_s;
	end

	// Power enables.  The reference is not switched here; it stays on in nap.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			comparator_on <= 1'b1;
			analog_on     <= 1'b1;
		end else begin
			comparator_on <= power_next;
			analog_on     <= power_next;
		end
	end

	// Output drive: enabled while chip select and read are both low.  With both
	// tied low the lines are always driven; otherwise they float between reads.
	wire drive = ~cs_n_s & ~rd_n_s;

	// The byte-wide variant drives only the lower eight lines.
	assign data_oe = BYTE_WIDE ? {4'h0, {8{drive}}} : {12{drive}};

	// Byte lane selection.  The select is a pin, so a change shows on the lines
	// three cycles later; the host must allow that before it reads.
	always @* begin
		if (!BYTE_WIDE)
			data_next = result_reg;
		else if (ubs_s)
			data_next = {8'h00, result_reg[11:8]};
		else
			data_next = {4'h0, result_reg[7:0]};
	end

	// Data lines come from a register so that they never glitch on a select change.
	// The cost is one cycle between a new result and its appearance on the lines.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_out <= 12'h000;
		end else begin
			data_out <= data_next;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/sacc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// Pin inputs reach the core through two sync stages, so causes are looked up three cycles back.
module sacc_chk #(
	parameter int CONV_CYC  = 40,
	parameter bit BYTE_WIDE = 1'b0
) (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        chip_select_n,
	input wire logic        read_n,
	input wire logic        sleep_n,
	input wire logic        nap_n,
	input wire logic        busy_n,
	input wire logic        reference_settled,
	input wire logic        comparator_on,
	input wire logic        analog_on,
	input wire logic [11:0] data_oe,
	input wire logic        conv_done
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	property p_len; $fell(busy_n) |-> ##CONV_CYC $rose(busy_n); endproperty
	a_len: assert property (p_len) else $error("busy low time wrong");
	property p_done; conv_done == $rose(busy_n); endproperty
	a_done: assert property (p_done) else $error("done pulse off busy edge");
	property p_cs; $fell(busy_n) |-> $past(!chip_select_n, 3); endproperty
	a_cs: assert property (p_cs) else $error("start without select");
	property p_sleep; $fell(busy_n) |-> $past(sleep_n, 3) && analog_on; endproperty
	a_sleep: assert property (p_sleep) else $error("start while asleep");
	property p_ref; $rose(sleep_n) |-> !reference_settled[*8] ##[1:25] reference_settled; endproperty
	a_ref: assert property (p_ref) else $error("reference ready timing");
	property p_nap; !nap_n[*5] |-> !analog_on && reference_settled; endproperty
	a_nap: assert property (p_nap) else $error("nap power state");
	property p_cmp; (sleep_n && nap_n)[*5] |-> comparator_on; endproperty
	a_cmp: assert property (p_cmp) else $error("comparator not up");
	property p_oe; (!chip_select_n && !read_n)[*4] |-> data_oe == (BYTE_WIDE ? 12'h0FF : 12'hFFF); endproperty
	a_oe: assert property (p_oe) else $error("outputs not driven");
	property p_float; read_n[*4] |-> data_oe == 12'h000; endproperty
	a_float: assert property (p_float) else $error("outputs not floated");
endmodule
bind sacc_top sacc_chk #(.CONV_CYC(CONV_CYC), .BYTE_WIDE(BYTE_WIDE)) chk_u (.clock, .rstn, .chip_select_n, .read_n, .sleep_n,
	.nap_n, .busy_n, .reference_settled, .comparator_on, .analog_on, .data_oe, .conv_done);
`default_nettype wire

// ---- testbench/sacc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host bus model; strobes move just after a rising edge.
module sacc_host (
	input  wire logic clock,
	input  wire logic busy_n,
	output var logic  chip_select_n,
	output var logic  read_n,
	output var logic  conversion_start_n
);
	initial {chip_select_n, read_n, conversion_start_n} = 3'b001;
	// A narrow high pulse, so the line stays low through the conversion.
	task automatic start(input logic cs_n, input logic rd_n);
		@(posedge clock) #1 {chip_select_n, read_n, conversion_start_n} = {cs_n, rd_n, 1'b1};
		repeat (3) @(posedge clock);
		#1 conversion_start_n = 1'b0;
	endtask
	// Read tied to start: one low both starts and reads, then wait out busy.
	task automatic slow;
		@(posedge clock) #1 {chip_select_n, read_n, conversion_start_n} = 3'h3;
		repeat (3) @(posedge clock);
		#1 {read_n, conversion_start_n} = 2'h0;
		@(posedge clock);
		while (busy_n) @(posedge clock);
		while (!busy_n) @(posedge clock);
		#1 {read_n, conversion_start_n} = 2'h3;
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_sacc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sacc_top;
	logic        clock = 0;
	logic        rstn = 0;
	logic        sleep_n = 1;
	logic        nap_n = 1;
	logic        bipolar = 0;
	logic        ubs = 0;
	wire  [11:0] dout_b, doe_b;
	logic [11:0] code = 12'h000;
	logic [11:0] r;
	logic [11:0] bp[3] = '{12'h7FF, 12'h800, 12'hFFE};
	logic [11:0] exp_q[$];
	integer      fail_count = 0, tests_run = 0, seed = 56693, i;
	wire         cs_n, rd_n, cst_n, busy_n, ref_ok, done;
	wire  [11:0] dout, doe;
	sacc_host host_u (.clock(clock), .busy_n(busy_n), .chip_select_n(cs_n), .read_n(rd_n),
		.conversion_start_n(cst_n));
	sacc_top #(.CONV_CYC(40), .SLEEP_CYC(20), .NAP_CYC(5), .BYTE_WIDE(1'b1)) byte_u (.clock(clock),
		.rstn(rstn), .chip_select_n(cs_n), .read_n(rd_n), .conversion_start_n(cst_n), .upper_byte_select(ubs),
		.sleep_n(sleep_n), .nap_n(nap_n), .bipolar(bipolar), .sample_valid(1'b1), .sample_code(code),
		.busy_n(), .reference_settled(), .comparator_on(), .analog_on(), .data_out(dout_b),
		.data_oe(doe_b), .conv_done());
	sacc_top #(.CONV_CYC(40), .SLEEP_CYC(20), .NAP_CYC(5)) dut_u (.clock(clock), .rstn(rstn),
		.chip_select_n(cs_n), .read_n(rd_n), .conversion_start_n(cst_n), .upper_byte_select(ubs),
		.sleep_n(sleep_n), .nap_n(nap_n), .bipolar(bipolar), .sample_valid(1'b1), .sample_code(code),
		.busy_n(busy_n), .reference_settled(ref_ok), .comparator_on(), .analog_on(), .data_out(dout),
		.data_oe(doe), .conv_done(done));
	// Clock of 4 ns period.
	always #2 clock = ~clock;
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Queue the result only when the start must be taken; the wait covers lag plus conversion.
	task automatic conv(input logic [11:0] c, input logic [11:0] e, input logic cs, rd, ok);
		code = c;
		if (ok) exp_q.push_back(e);
		host_u.start(cs, rd);
		repeat (60) @(posedge clock);
		#1;
	endtask
	// A completion pops the oldest note; the new result shows one cycle later.
	always @(posedge clock) if (done === 1'b1) begin
		@(posedge clock) #1;
		if (exp_q.size() == 0)
			check("spurious done", 12'h001, 12'h000);
		else
			check("result", dout, exp_q.pop_front());
	end
	// Main sequence.
	initial begin
		repeat (12) @(posedge clock);
		#1 rstn = 1;
		repeat (4) @(posedge clock);
		#1 check("idle busy", {11'h000, busy_n}, 12'h001);
		check("oe", doe, 12'hFFF);
		for (i = 0; i < 4; i++) begin
			r = $random(seed);
			conv(r, r, 0, 0, 1);
		end
		ubs = 1;
		repeat (4) @(posedge clock);
		#1 check("upper byte", dout_b, {8'h00, r[11:8]});
		check("byte oe", doe_b, 12'h0FF);
		ubs = 0;
		repeat (4) @(posedge clock);
		#1 check("lower byte", dout_b, {4'h0, r[7:0]});
		fork
			conv(12'h5A5, 12'h5A5, 0, 0, 1);
			begin repeat (20) @(posedge clock); host_u.start(0, 0); end
		join
		conv(12'h0F0, 12'h0F0, 1, 0, 0);
		conv(12'h3C3, 12'h3C3, 0, 1, 1);
		check("oe off", doe, 12'h000);
		sleep_n = 0;
		conv(12'h123, 12'h123, 0, 0, 0);
		sleep_n = 1;
		repeat (3) @(posedge clock);
		#1 check("ref low", {11'h000, ref_ok}, 12'h000);
		repeat (30) @(posedge clock);
		#1 check("ref high", {11'h000, ref_ok}, 12'h001);
		nap_n = 0;
		repeat (10) @(posedge clock);
		#1 nap_n = 1;
		repeat (12) @(posedge clock);
		#1 bipolar = 1;
		foreach (bp[k]) conv(bp[k], bp[k] ^ 12'h800, 0, 0, 1);
		code = 12'h456;
		exp_q.push_back(12'hC56);
		host_u.slow();
		repeat (8) @(posedge clock);
		#1 test_done;
	end
	// Limit far beyond the roughly 840 cycles the sequence needs.
	initial begin
		#20000;
		fail_count++;
		test_done;
	end
endmodule
`default_nettype wire
